// >>> design/sfe_erase_ctrl.sv
module sfe_erase_ctrl
  import sfe_pkg::*;
#(
  parameter longint unsigned SECTOR_ERASE_US   = 70000,
  parameter longint unsigned BLOCK_ERASE_US    = 250000,
  parameter longint unsigned ARRAY_ERASE_US    = 100000000,
  parameter longint unsigned SUSPEND_LATENCY_US = 30
)
(
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              spiCsN,
  input  wire logic              spiClk,
  input  wire logic              spiDataIn,
  output logic                   spiDataOut,
  output logic                   spiDataOutEn,
  input  wire logic [4:0]        protectLevelBits,
  input  wire logic              addrProtected,
  input  wire logic              statusWriteBusy,
  input  wire logic [ADDR_W-1:0] accessAddr,
  output logic [ADDR_W-1:0]      probeAddr,
  output sfe_kind_t              probeKind,
  output logic                   busyFlag,
  output logic                   writeLatchFlag,
  output logic                   suspendFlag,
  output sfe_erase_t             eraseReq,
  output logic                   eraseRun,
  output logic [7:0]             eraseFill,
  output logic                   accessBlocked
);
  // ==========================================================
  // timing counts
  localparam longint unsigned SE_CYC = SECTOR_ERASE_US * 1000 / CLK_PERIOD_NS;
  localparam longint unsigned BE_CYC = BLOCK_ERASE_US * 1000 / CLK_PERIOD_NS;
  localparam longint unsigned CE_CYC = ARRAY_ERASE_US * 1000 / CLK_PERIOD_NS;
  localparam longint unsigned LAT_CYC =
    SUSPEND_LATENCY_US * 1000 / CLK_PERIOD_NS;

  // ==========================================================
  // state record
  typedef struct packed {
    logic               csSync1;
    logic               csSync2;
    logic               csPrev;
    logic               clkSync1;
    logic               clkSync2;
    logic               clkPrev;
    logic               dinSync1;
    logic               dinSync2;
    logic [31:0]        shift;
    logic [5:0]         bitCnt;
    logic               write_latch_flag;
    logic               suspend_flag;
    sfe_state_e_t       state;
    sfe_erase_t         req;
    logic [TIMER_W-1:0] timer;
    logic [LAT_W-1:0]   latCnt;
    logic               rdOn;
    logic               rdHi;
    logic [7:0]         outSh;
    logic [2:0]         outCnt;
    logic               dout;
    logic               doutEn;
    logic               blocked;
  } sfe_state_t;

  sfe_state_t s_r;
  sfe_state_t s_nxt;

  logic              sclkRise;
  logic              sclkFall;
  logic              csRise;
  logic              csFall;
  logic              busy;
  logic [7:0]        op8;
  logic [7:0]        opA;
  logic [ADDR_W-1:0] lockMask;

  // unit size of an erase kind as a low-address mask
  function automatic logic [ADDR_W-1:0] unitMask(input sfe_kind_t k);
    case (k)
      KIND_SECTOR: return ADDR_W'((1 << SECTOR_LOW) - 1);
      KIND_BLK32:  return ADDR_W'((1 << BLK32_LOW) - 1);
      KIND_BLK64:  return ADDR_W'((1 << BLK64_LOW) - 1);
      default:     return '1;
    endcase
  endfunction

  // erase kind of an addressed opcode
  function automatic sfe_kind_t opKind(input logic [7:0] op);
    case (op)
      OP_SECTOR: return KIND_SECTOR;
      OP_BLK32:  return KIND_BLK32;
      OP_BLK64:  return KIND_BLK64;
      default:   return KIND_ARRAY;
    endcase
  endfunction

  // status byte, low half or high half of the status word
  function automatic logic [7:0] statByte(input logic hi,
                                          input logic bsy,
                                          input logic wl,
                                          input logic su);
    logic [15:0] w;
    w = '0;
    w[STAT_BUSY_BIT] = bsy;
    w[STAT_WEL_BIT]  = wl;
    w[STAT_SUS_BIT]  = su;
    return hi ? w[15:8] : w[7:0];
  endfunction

  // ==========================================================
  // edge detection on synchronised link pins
  assign sclkRise = s_r.clkSync2 & ~s_r.clkPrev & ~s_r.csSync2;
  assign sclkFall = ~s_r.clkSync2 & s_r.clkPrev & ~s_r.csSync2;
  assign csRise   = s_r.csSync2 & ~s_r.csPrev;
  assign csFall   = ~s_r.csSync2 & s_r.csPrev;
  assign busy     = (s_r.state == ST_ERASE) ||
                    (s_r.state == ST_SUSP_WAIT);
  assign op8      = s_r.shift[7:0];
  assign opA      = s_r.shift[31:24];
  assign lockMask = unitMask(s_r.req.kind);

  // ==========================================================
  // next-state logic
  always_comb
  begin
    s_nxt           = s_r;
    s_nxt.req.start = 1'b0;
    // two-flop synchronisers on select, clock and data
    s_nxt.csSync1   = spiCsN;
    s_nxt.csSync2   = s_r.csSync1;
    s_nxt.csPrev    = s_r.csSync2;
    s_nxt.clkSync1  = spiClk;
    s_nxt.clkSync2  = s_r.clkSync1;
    s_nxt.clkPrev   = s_r.clkSync2;
    s_nxt.dinSync1  = spiDataIn;
    s_nxt.dinSync2  = s_r.dinSync1;
    // frame start clears the bit count and output
    if (csFall)
    begin
      s_nxt.bitCnt = '0;
      s_nxt.rdOn   = 1'b0;
      s_nxt.doutEn = 1'b0;
    end
    // shift in one bit per rising serial clock edge
    if (sclkRise)
    begin
      s_nxt.shift = {s_r.shift[30:0], s_r.dinSync2};
      if (s_r.bitCnt != BIT_CNT_MAX)
        s_nxt.bitCnt = s_r.bitCnt + 6'h01;
    end

    // status read output, refreshed each byte so busy is live
    if (sclkFall && (s_r.rdOn || (s_r.bitCnt == OPCODE_BITS &&
        (op8 == OP_STAT_LO || op8 == OP_STAT_HI))))
    begin
      s_nxt.rdOn   = 1'b1;
      s_nxt.doutEn = 1'b1;
      s_nxt.rdHi   = s_r.rdOn ? s_r.rdHi : (op8 == OP_STAT_HI);
      if (!s_r.rdOn || s_r.outCnt == 3'h0)
        s_nxt.outSh = statByte(s_nxt.rdHi, busy, s_r.write_latch_flag, s_r.suspend_flag);
      s_nxt.dout   = s_nxt.outSh[7];
      s_nxt.outSh  = {s_nxt.outSh[6:0], 1'b0};
      s_nxt.outCnt = s_r.rdOn ? s_r.outCnt + 3'h1 : 3'h1;
    end
    if (csRise)
      s_nxt.doutEn = 1'b0;
    // erase engine: timer runs, suspend latency counts down
    case (s_r.state)
      ST_IDLE, ST_SUSPENDED:
        s_nxt.state = s_r.state;
      ST_ERASE:
        if (s_r.timer == '0)
          s_nxt.state = ST_IDLE;
        else
          s_nxt.timer = s_r.timer - 1'b1;
      ST_SUSP_WAIT:
        if (s_r.latCnt == '0)
        begin
          s_nxt.state = ST_SUSPENDED;
          s_nxt.write_latch_flag   = 1'b0;
          s_nxt.suspend_flag   = 1'b1;
        end
        else
          s_nxt.latCnt = s_r.latCnt - 1'b1;
      default:
        s_nxt.state = ST_IDLE;
    endcase
    // commands take effect on select rising
    if (csRise && s_r.bitCnt == OPCODE_BITS)
    begin
      case (op8)
        OP_WREN:
          if (!busy)
            s_nxt.write_latch_flag = 1'b1;
        OP_WRDI:
          if (!busy)
            s_nxt.write_latch_flag = 1'b0;
        OP_ARRAY_A, OP_ARRAY_B:
          if (!busy && !s_r.suspend_flag && s_r.write_latch_flag &&
              protectLevelBits == '0)
          begin
            s_nxt.state     = ST_ERASE;
            s_nxt.timer     = TIMER_W'(CE_CYC - 1);
            s_nxt.req.start = 1'b1;
            s_nxt.req.kind  = KIND_ARRAY;
            s_nxt.req.addr  = '0;
            s_nxt.write_latch_flag       = 1'b0;
          end
        OP_SUSPEND:
          if (s_r.state == ST_ERASE && s_r.timer != '0 &&
              s_r.req.kind != KIND_ARRAY &&
              !statusWriteBusy)
          begin
            s_nxt.state  = ST_SUSP_WAIT;
            s_nxt.timer  = s_r.timer;
            s_nxt.latCnt = LAT_W'(LAT_CYC);
          end
        OP_RESUME:
          if (s_r.suspend_flag && !busy)
          begin
            s_nxt.suspend_flag   = 1'b0;
            s_nxt.state = ST_ERASE;
          end
        default: s_nxt.write_latch_flag = s_nxt.write_latch_flag;
      endcase
    end
    else if (csRise && s_r.bitCnt == ADDR_CMD_BITS &&
             (opA == OP_SECTOR || opA == OP_BLK32 ||
              opA == OP_BLK64))
    begin
      if (!busy && !s_r.suspend_flag && s_r.write_latch_flag &&
          !addrProtected)
      begin
        s_nxt.state     = ST_ERASE;
        s_nxt.timer     = TIMER_W'(((opA == OP_SECTOR) ? SE_CYC
                                     : BE_CYC) - 1);
        s_nxt.req.start = 1'b1;
        s_nxt.req.kind  = opKind(opA);
        s_nxt.req.addr  = s_r.shift[23:0] &
                          ~unitMask(opKind(opA));
        s_nxt.write_latch_flag       = 1'b0;
      end
    end
    // accesses into the paused unit are flagged
    s_nxt.blocked = s_r.suspend_flag && ((accessAddr & ~lockMask) ==
                                s_r.req.addr);
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_r         <= '0;
      s_r.csSync1 <= 1'b1; // select idles high: no false rise
      s_r.csSync2 <= 1'b1;
      s_r.csPrev  <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  // ==========================================================
  // outputs
  assign spiDataOut     = s_r.dout;
  assign spiDataOutEn   = s_r.doutEn;
  assign probeAddr      = s_r.shift[23:0];
  assign probeKind      = opKind(opA);
  assign busyFlag       = busy;
  assign writeLatchFlag = s_r.write_latch_flag;
  assign suspendFlag    = s_r.suspend_flag;
  assign eraseReq       = s_r.req;
  assign eraseRun       = (s_r.state == ST_ERASE);
  assign eraseFill      = ERASED_BYTE;
  assign accessBlocked  = s_r.blocked;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  property p_start_wel;
    eraseReq.start |-> $past(s_r.write_latch_flag) && !writeLatchFlag;
  endproperty
  a_start_wel: assert property (p_start_wel)
    else $error("erase started without write latch");

  property p_start_edge;
    eraseReq.start |-> $past(csRise);
  endproperty
  a_start_edge: assert property (p_start_edge)
    else $error("erase started without select rise");

  property p_busy_start;
    eraseReq.start |-> busyFlag && eraseRun;
  endproperty
  a_busy_start: assert property (p_busy_start)
    else $error("busy not set at erase start");

  property p_busy_hold;
    eraseRun && s_r.timer != '0 |=> busyFlag;
  endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("busy dropped before erase time");

  property p_array_prot;
    eraseReq.start && eraseReq.kind == KIND_ARRAY
      |-> $past(protectLevelBits) == '0;
  endproperty
  a_array_prot: assert property (p_array_prot)
    else $error("array erase with protection set");

  property p_unit_prot;
    eraseReq.start && eraseReq.kind != KIND_ARRAY
      |-> !$past(addrProtected) && (eraseReq.addr & 24'h000fff) == '0;
  endproperty
  a_unit_prot: assert property (p_unit_prot)
    else $error("protected or misaligned unit erased");

  property p_no_restart;
    busyFlag |=> !eraseReq.start;
  endproperty
  a_no_restart: assert property (p_no_restart)
    else $error("erase accepted while busy");

  property p_sus_set;
    $rose(suspendFlag) |-> !writeLatchFlag && !busyFlag;
  endproperty
  a_sus_set: assert property (p_sus_set)
    else $error("suspend flag set with latch or busy");

  property p_resume;
    $fell(suspendFlag) |-> busyFlag && eraseRun;
  endproperty
  a_resume: assert property (p_resume)
    else $error("resume did not restart erase");
endmodule

// >>> design/sfe_pkg.sv
package sfe_pkg;
  // ==========================================================
  // clock and field sizes
  localparam int          CLK_PERIOD_NS  = 5;
  localparam int          TIMER_W        = 40;
  localparam int          LAT_W          = 24;
  localparam int          ADDR_W         = 24;
  localparam logic [5:0]  OPCODE_BITS    = 6'h08;
  localparam logic [5:0]  ADDR_CMD_BITS  = 6'h20;
  localparam logic [5:0]  BIT_CNT_MAX    = 6'h21;
  localparam int          SECTOR_LOW     = 12;
  localparam int          BLK32_LOW      = 15;
  localparam int          BLK64_LOW      = 16;
  localparam logic [7:0]  ERASED_BYTE    = 8'hff;
  // ==========================================================
  // opcodes
  localparam logic [7:0]  OP_WREN        = 8'h06;
  localparam logic [7:0]  OP_WRDI        = 8'h04;
  localparam logic [7:0]  OP_STAT_LO     = 8'h05;
  localparam logic [7:0]  OP_STAT_HI     = 8'h35;
  localparam logic [7:0]  OP_SECTOR      = 8'h20;
  localparam logic [7:0]  OP_BLK32       = 8'h52;
  localparam logic [7:0]  OP_BLK64       = 8'hd8;
  localparam logic [7:0]  OP_ARRAY_A     = 8'hc7;
  localparam logic [7:0]  OP_ARRAY_B     = 8'h60;
  localparam logic [7:0]  OP_SUSPEND     = 8'h75;
  localparam logic [7:0]  OP_RESUME      = 8'h7a;
  // ==========================================================
  // status bit positions within the 16-bit status word
  localparam int          STAT_BUSY_BIT  = 0;
  localparam int          STAT_WEL_BIT   = 1;
  localparam int          STAT_SUS_BIT   = 15;
  // ==========================================================
  // types
  typedef enum logic [1:0] {
    KIND_SECTOR = 2'h0,
    KIND_BLK32  = 2'h1,
    KIND_BLK64  = 2'h2,
    KIND_ARRAY  = 2'h3
  } sfe_kind_t;

  typedef enum logic [1:0] {
    ST_IDLE      = 2'h0,
    ST_ERASE     = 2'h1,
    ST_SUSP_WAIT = 2'h3,
    ST_SUSPENDED = 2'h2
  } sfe_state_e_t;

  typedef struct packed {
    logic              start;
    sfe_kind_t         kind;
    logic [ADDR_W-1:0] addr;
  } sfe_erase_t;
endpackage

// >>> verification/sfe_host_model.sv
module sfe_host_model
  import sfe_pkg::*;
(
  input  wire logic clk,
  output logic      csN,
  output logic      sclk,
  output logic      mosi,
  input  wire logic miso
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle link: select high, clock parked low
  initial
  begin
    csN  = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end

  // =========================================================
  // one frame of n bits, msb first; bits after byte one read back
  task automatic frame(input logic [31:0] d, input int n,
                       output logic [7:0] rd);
    rd = 8'h00;
    @(posedge clk) csN <= 1'b0;
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk) mosi <= (i < 32) ? d[31-i] : 1'b0;
      repeat (12) @(posedge clk);
      sclk <= 1'b1;
      repeat (12) @(posedge clk);
      if (i >= 8)
        rd = {rd[6:0], miso};
      sclk <= 1'b0;
    end
    repeat (13) @(posedge clk);
    csN  <= 1'b1;
    mosi <= ~mosi; // released line shows no stale value
    repeat (8) @(posedge clk);
  endtask
endmodule

// >>> verification/tb.sv
module tb
  import sfe_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int SE_CYC  = 2000;
  localparam int BE_CYC  = 2400;
  localparam int CE_CYC  = 2800;
  localparam int LAT_CYC = 200;

  logic              clk;
  logic              resetn;
  logic              spiCsN;
  logic              spiClk;
  logic              spiDataIn;
  logic              spiDataOut;
  logic              spiDataOutEn;
  logic [4:0]        protectLevelBits;
  logic              addrProtected;
  logic              protSect;
  logic              statusWriteBusy;
  logic [ADDR_W-1:0] accessAddr;
  logic [ADDR_W-1:0] probeAddr;
  sfe_kind_t         probeKind;
  logic              busyFlag;
  logic              writeLatchFlag;
  logic              suspendFlag;
  sfe_erase_t        eraseReq;
  logic              eraseRun;
  logic [7:0]        eraseFill;
  logic              accessBlocked;
  logic              enSeen;
  logic [7:0]        rd;
  logic [23:0]       a;
  logic [25:0]       expQ[$];
  int                miscompares;
  int                comparisons;
  int                seed;
  int                busyCnt;

  // outside protection decode: 64K region at f00000 when armed
  assign addrProtected = protSect & (probeAddr[23:16] == 8'hf0);

  sfe_erase_ctrl #(
    .SECTOR_ERASE_US    (10),
    .BLOCK_ERASE_US     (12),
    .ARRAY_ERASE_US     (14),
    .SUSPEND_LATENCY_US (1)
  ) uut (
    .clk              (clk),
    .resetn           (resetn),
    .spiCsN           (spiCsN),
    .spiClk           (spiClk),
    .spiDataIn        (spiDataIn),
    .spiDataOut       (spiDataOut),
    .spiDataOutEn     (spiDataOutEn),
    .protectLevelBits (protectLevelBits),
    .addrProtected    (addrProtected),
    .statusWriteBusy  (statusWriteBusy),
    .accessAddr       (accessAddr),
    .probeAddr        (probeAddr),
    .probeKind        (probeKind),
    .busyFlag         (busyFlag),
    .writeLatchFlag   (writeLatchFlag),
    .suspendFlag      (suspendFlag),
    .eraseReq         (eraseReq),
    .eraseRun         (eraseRun),
    .eraseFill        (eraseFill),
    .accessBlocked    (accessBlocked)
  );

  sfe_host_model host (
    .clk  (clk),
    .csN  (spiCsN),
    .sclk (spiClk),
    .mosi (spiDataIn),
    .miso (spiDataOut)
  );

  // 200 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // =========================================================
  // checking helpers
  task automatic end_of_test;
    if (miscompares == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic op(input logic [7:0] o);
    host.frame({o, 24'h0}, 8, rd);
  endtask

  // erase frame; expected unit base noted when it must start
  task automatic erase(input sfe_kind_t k, input logic [23:0] ad,
                       input logic ok);
    logic [23:0] m;
    m = (k == KIND_SECTOR) ? 24'hfff000 :
        (k == KIND_BLK32) ? 24'hff8000 : 24'hff0000;
    if (ok)
      expQ.push_back({k, ad & m});
    host.frame({(k == KIND_SECTOR) ? OP_SECTOR :
                (k == KIND_BLK32) ? OP_BLK32 : OP_BLK64, ad}, 32, rd);
  endtask

  // bounded wait for idle; busy span checked when n is given
  task automatic waitIdle(input int n);
    int c;
    c = 0;
    while (busyFlag === 1'b1 && c < 4000)
    begin
      @(posedge clk);
      c++;
    end
    if (c >= 4000)
    begin
      miscompares++;
      end_of_test;
    end
    if (n > 0)
      chk(busyCnt, n);
  endtask

  // watcher: every erase start takes the oldest note
  always @(posedge clk)
  begin
    if (spiDataOutEn === 1'b1)
      enSeen = 1'b1;
    if (eraseReq.start === 1'b1)
    begin
      busyCnt = 0;
      chk({eraseReq.kind, eraseReq.addr},
          (expQ.size() > 0) ? expQ.pop_front() : 26'hx);
    end
    // busy span in cycles since the last erase start
    if (busyFlag === 1'b1)
      busyCnt++;
  end

  // =========================================================
  // main sequence
  initial
  begin
    seed = 13754;
    miscompares = 0;
    comparisons = 0;
    busyCnt = 0;
    enSeen = 1'b0;
    resetn = 1'b0;
    protectLevelBits = 5'h00;
    protSect = 1'b0;
    statusWriteBusy = 1'b0;
    accessAddr = 24'h0;
    cyc(10);
    chk({busyFlag, writeLatchFlag, suspendFlag, eraseRun}, 4'h0);
    resetn <= 1'b1;
    cyc(6);
    chk(eraseFill, 8'hff);
    // each unit size, random address, status poll while erasing
    for (int k = 0; k < 3; k++)
    begin
      a = $random(seed) & 24'h0fffff;
      op(OP_WREN);
      chk(writeLatchFlag, 1'b1);
      erase(sfe_kind_t'(k), a, 1'b1);
      chk({busyFlag, writeLatchFlag}, 2'h2);
      enSeen = 1'b0;
      host.frame({OP_STAT_LO, 24'h0}, 16, rd);
      chk(rd[1:0], 2'h1);
      chk({enSeen, spiDataOutEn}, 2'h2);
      waitIdle(k == 0 ? SE_CYC : BE_CYC);
    end
    // whole-array erase from both opcodes
    for (int i = 0; i < 2; i++)
    begin
      op(OP_WREN);
      expQ.push_back({KIND_ARRAY, 24'h0});
      op(i == 0 ? OP_ARRAY_A : OP_ARRAY_B);
      op(OP_SUSPEND);
      chk({eraseRun, suspendFlag, busyFlag}, 3'h5);
      waitIdle(CE_CYC);
      chk(writeLatchFlag, 1'b0);
    end
    // refused frames: no latch, wrong counts, protection
    op(OP_WREN);
    op(OP_WRDI);
    chk(writeLatchFlag, 1'b0);
    erase(KIND_SECTOR, a, 1'b0);
    op(OP_WREN);
    host.frame({OP_SECTOR, a}, 31, rd);
    host.frame({OP_SECTOR, a}, 33, rd);
    host.frame({OP_ARRAY_A, 24'h0}, 9, rd);
    host.frame({OP_ARRAY_B, 24'h0}, 7, rd);
    protSect <= 1'b1;
    erase(KIND_BLK64, 24'hf01234, 1'b0);
    chk(probeKind, KIND_BLK64);
    protectLevelBits <= 5'h04;
    op(OP_ARRAY_B);
    chk({busyFlag, writeLatchFlag}, 2'h1);
    protectLevelBits <= 5'h00;
    protSect <= 1'b0;
    // busy device ignores latch set and new erase
    erase(KIND_SECTOR, a, 1'b1);
    op(OP_WREN);
    chk(writeLatchFlag, 1'b0);
    erase(KIND_BLK32, a, 1'b0);
    waitIdle(SE_CYC);
    // suspend, blocked unit, resume
    a = $random(seed) & 24'h0fffff;
    op(OP_WREN);
    erase(KIND_SECTOR, a, 1'b1);
    cyc(20);
    statusWriteBusy <= 1'b1;
    op(OP_SUSPEND);
    cyc(LAT_CYC + 10);
    chk(suspendFlag, 1'b0);
    statusWriteBusy <= 1'b0;
    op(OP_SUSPEND);
    chk({busyFlag, eraseRun, suspendFlag}, 3'h4);
    cyc(LAT_CYC + 4);
    chk({busyFlag, writeLatchFlag, suspendFlag}, 3'h1);
    host.frame({OP_STAT_HI, 24'h0}, 16, rd);
    chk(rd[7], 1'b1);
    accessAddr <= a;
    cyc(3);
    chk(accessBlocked, 1'b1);
    accessAddr <= a ^ 24'h001000;
    cyc(3);
    chk(accessBlocked, 1'b0);
    op(OP_RESUME);
    chk({busyFlag, eraseRun, suspendFlag}, 3'h6);
    waitIdle(0);
    op(OP_RESUME);
    chk({busyFlag, suspendFlag, eraseRun}, 3'h0);
    chk(expQ.size(), 0);
    end_of_test;
  end
endmodule
